/* File: bench/bdm_addr_gen_properties.sv */
// Port assertions for the address generator
`timescale 1ns/100ps
`default_nettype none
module bdm_props #(parameter IMPL_BANKS = 16'h8001) (
  input wire clk_i, rstn_i, start_i, access_sel_i, full_move_i, extended_isa_enable_i,
  input wire bank_load_i, rd_valid_o, pc_low_wr_o, done_o,
  input wire [7:0] ofs_i, bank_lit_i, rd_data_o, bank_pointer_o,
  input wire [11:0] src_addr_i, rd_addr_o);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_done; ##2 done_o; endsequence
  // Start is sampled three edges before read valid is seen: take, phase 0, phase 1
  AST_RD: assert property (rd_valid_o |-> $past(start_i, 3)) else $error("read late");
  AST_DONE: assert property (rd_valid_o |-> s_done) else $error("done late");
  AST_HIGH: assert property (bank_pointer_o[7:4] == 4'h0) else $error("bank high");
  AST_LOAD: assert property (bank_load_i |=> bank_pointer_o == ($past(bank_lit_i) & 8'h0f))
    else $error("bank load");
  AST_ACC: assert property (rd_valid_o && !$past(access_sel_i, 3) && !$past(full_move_i, 3)
    && !$past(extended_isa_enable_i, 3) |-> rd_addr_o[11:8] == ($past(ofs_i, 3) < 8'h60 ? 4'h0 : 4'hf))
    else $error("access map");
  AST_BANK: assert property (rd_valid_o && $past(access_sel_i, 3) && !$past(full_move_i, 3)
    |-> rd_addr_o == {bank_pointer_o[3:0], $past(ofs_i, 3)}) else $error("banked");
  AST_FULL: assert property (rd_valid_o && $past(full_move_i, 3)
    |-> rd_addr_o == $past(src_addr_i, 3)) else $error("full move");
  AST_ZERO: assert property (rd_valid_o && !IMPL_BANKS[rd_addr_o[11:8]] |-> rd_data_o == 8'h00)
    else $error("not zero");
endmodule
bind bdm_addr_gen bdm_props #(.IMPL_BANKS(IMPL_BANKS)) u_props (.*);
`default_nettype wire

/* File: bench/bdm_addr_gen_test.sv */
// Directed bench for the address generator
`timescale 1ns/100ps
`default_nettype none
module bdm_addr_gen_test;
  reg clk_i = 1'h0, rstn_i = 1'h0, st = 1'h0, s = 1'h0, f = 1'h0, w = 1'h0, bl = 1'h0;
  reg [7:0] o = 8'h00, lit = 8'h00, d = 8'h00, rd;
  reg [11:0] a = 12'h000, ra, wa;
  reg pc, cw;
  integer fails = 0, samples_checked = 0;
  wire [7:0] crd, rdo, wdo, bp;
  wire [11:0] rao, wao;
  wire rv, cwo, pco, dno;
  always #20 clk_i = ~clk_i;
  bdm_addr_gen DUT (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'h1), .start_i(st), .ofs_i(o),
    .access_sel_i(s), .full_move_i(f), .src_addr_i(a), .dst_addr_i(12'h020), .bank_load_i(bl),
    .bank_lit_i(lit), .wr_en_i(w), .wr_data_i(d), .extended_isa_enable_i(1'h0),
    .ctrl_rdata_i(crd), .rd_addr_o(rao), .wr_addr_o(wao), .rd_data_o(rdo), .rd_valid_o(rv),
    .ctrl_wr_o(cwo), .ctrl_wdata_o(wdo), .pc_low_wr_o(pco), .done_o(dno), .bank_pointer_o(bp));
  bdm_core_model CORE (.clk_i(clk_i), .wr_i(cwo), .wdata_i(wdo), .rdata_o(crd));
  task chk(input [11:0] g, e);
    samples_checked++;
    if (g !== e) fails++;
    if (g !== e) $display("wrong value at %0t: %h vs %h", $time, g, e);
  endtask
  // Every access reloads the bank pointer first, so each call fixes its own bank
  task acc(input [7:0] xl, input [2:0] m, input [7:0] xo, xd);
    @(posedge clk_i);
    {bl, lit} <= {1'h1, xl};
    @(posedge clk_i);
    {bl, st, s, f, w, o, a, d} <= {2'h1, m, xo, 4'h0, xo, xd};
    @(posedge clk_i);
    st <= 1'h0;
    repeat (2) @(posedge clk_i);
    #1 {rd, ra} = {rdo, rao};
    repeat (2) @(posedge clk_i);
    #1 {wa, pc, cw} = {wao, pco, cwo};
    chk(dno, 12'h001);
  endtask
  task t_banks;
    chk(bp, 12'h000);
    acc(8'h00, 3'h1, 8'h5f, 8'h3c);
    acc(8'hf0, 3'h4, 8'h5f, 8'h00);
    chk(rd, 12'h03c);
    acc(8'hf7, 3'h5, 8'h10, 8'hff);
    chk(wa, 12'h710);
    acc(8'h07, 3'h4, 8'h10, 8'h00);
    chk(rd, 12'h000);
    acc(8'h07, 3'h0, 8'h10, 8'h00);
    chk(ra, 12'h010);
  endtask
  task t_special;
    acc(8'h0f, 3'h5, 8'hf9, 8'h42);
    chk(pc, 12'h001);
    acc(8'h0f, 3'h3, 8'h5f, 8'h3c);
    chk(wa, 12'h020);
    acc(8'h00, 3'h1, 8'h60, 8'h81);
    chk(cw, 12'h001);
    acc(8'h00, 3'h0, 8'h60, 8'h00);
    chk(rd, 12'h081);
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'h1;
    t_banks;
    t_special;
    test_done;
  end
  initial begin
    #20000 fails++;
    test_done;
  end
endmodule
`default_nettype wire

/* File: bench/bdm_core_model.sv */
// Core model holding the last control-area write
`timescale 1ns/100ps
`default_nettype none
module bdm_core_model (input wire clk_i, input wire wr_i, input wire [7:0] wdata_i,
  output logic [7:0] rdata_o = 8'h96);
  always @(posedge clk_i) if (wr_i) rdata_o <= wdata_i;
endmodule
`default_nettype wire

/* File: core/bdm_addr_gen.v */
// Banked data memory address generator with bank pointer and scratch RAM
`timescale 1ns/100ps
`default_nettype none
`include "bdm_defs.vh"
module bdm_addr_gen #(
  parameter IMPL_BANKS = 16'h8001,
  parameter GPR_BANKS = 16'h0001
) (
  // Clock, reset, enable
  input wire clk_i,
  input wire rstn_i,
  input wire ce_i,
  // Instruction controls
  input wire start_i,
  input wire [7:0] ofs_i,
  input wire access_sel_i,
  input wire full_move_i,
  input wire [11:0] src_addr_i,
  input wire [11:0] dst_addr_i,
  input wire bank_load_i,
  input wire [7:0] bank_lit_i,
  input wire wr_en_i,
  input wire [7:0] wr_data_i,
  input wire extended_isa_enable_i,
  // Control register read data from the core
  input wire [7:0] ctrl_rdata_i,
  // Outputs
  output reg [11:0] rd_addr_o,
  output reg [11:0] wr_addr_o,
  output reg [7:0] rd_data_o,
  output reg rd_valid_o,
  output reg ctrl_wr_o,
  output reg [7:0] ctrl_wdata_o,
  output reg pc_low_wr_o,
  output reg done_o,
  output wire [7:0] bank_pointer_o
);
  reg [3:0] bank_pointer_q;
  reg [1:0] q_q;
  reg busy_q;
  reg [11:0] raddr_q;
  reg [11:0] waddr_q;
  reg wr_q;
  reg [7:0] wdata_q;
  reg [7:0] mem [0:4095];
  reg [11:0] op_addr;
  reg [11:0] std_access;
  wire [3:0] rbank;
  wire [3:0] wbank;
  wire r_ctrl;
  wire w_ctrl;
  wire r_gpr;
  wire w_gpr;

  assign bank_pointer_o = {4'h0, bank_pointer_q};

  always @* begin
    std_access = {`BDM_ACCESS_LOW_BANK, ofs_i};
    if (ofs_i >= `BDM_ACCESS_SPLIT) begin
      std_access = {`BDM_ACCESS_HIGH_BANK, ofs_i};
    end
    op_addr = std_access;
    if (access_sel_i) begin
      op_addr = {bank_pointer_q, ofs_i};
    end else if (extended_isa_enable_i && ofs_i < `BDM_ACCESS_SPLIT) begin
      // Indexed mapping lives in the core; low window stays in bank 0 at its own offset below 0x60
      op_addr = {`BDM_ACCESS_LOW_BANK, ofs_i};
    end
    if (full_move_i) begin
      op_addr = src_addr_i;
    end
  end

  assign rbank = raddr_q[11:8];
  assign wbank = waddr_q[11:8];
  assign r_ctrl = raddr_q >= `BDM_CTRL_BASE;
  assign w_ctrl = waddr_q >= `BDM_CTRL_BASE;
  assign r_gpr = IMPL_BANKS[rbank] && GPR_BANKS[rbank] && !r_ctrl;
  assign w_gpr = IMPL_BANKS[wbank] && GPR_BANKS[wbank] && !w_ctrl;

  // Simple fixed four-phase sequence keeps read and write timing identical for all modes
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      bank_pointer_q <= `BDM_BANK_PTR_RESET;
      q_q <= 2'h0;
      busy_q <= 1'b0;
      raddr_q <= 12'h000;
      waddr_q <= 12'h000;
      wr_q <= 1'b0;
      wdata_q <= 8'h00;
      rd_addr_o <= 12'h000;
      wr_addr_o <= 12'h000;
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
      ctrl_wr_o <= 1'b0;
      ctrl_wdata_o <= 8'h00;
      pc_low_wr_o <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      rd_valid_o <= 1'b0;
      ctrl_wr_o <= 1'b0;
      pc_low_wr_o <= 1'b0;
      done_o <= 1'b0;
      if (bank_load_i) begin
        bank_pointer_q <= bank_lit_i[3:0];
      end
      if (!busy_q) begin
        if (start_i) begin
          busy_q <= 1'b1;
          q_q <= 2'h0;
          raddr_q <= op_addr;
          waddr_q <= full_move_i ? dst_addr_i : op_addr;
          wr_q <= wr_en_i;
          wdata_q <= wr_data_i;
        end
      end else begin
        q_q <= q_q + 2'h1;
        if (q_q == `BDM_Q_READ) begin
          rd_addr_o <= raddr_q;
          rd_valid_o <= 1'b1;
          if (raddr_q == `BDM_BANK_PTR_ADDR) begin
            // Bank pointer lives here, so its upper bits read back as zero
            rd_data_o <= {4'h0, bank_pointer_q};
          end else if (r_ctrl) begin
            rd_data_o <= ctrl_rdata_i;
          end else if (r_gpr) begin
            rd_data_o <= mem[raddr_q];
          end else begin
            rd_data_o <= 8'h00;
          end
        end
        if (q_q == `BDM_Q_WRITE) begin
          busy_q <= 1'b0;
          done_o <= 1'b1;
          wr_addr_o <= waddr_q;
          if (wr_q) begin
            if (w_gpr) begin
              mem[waddr_q] <= wdata_q;
            end
            if (w_ctrl) begin
              ctrl_wr_o <= 1'b1;
              ctrl_wdata_o <= wdata_q;
              pc_low_wr_o <= waddr_q == `BDM_PC_LOW_ADDR;
            end
            if (waddr_q == `BDM_BANK_PTR_ADDR) begin
              bank_pointer_q <= wdata_q[3:0];
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: core/bdm_defs.vh */
// Constants for the banked data memory address generator
`ifndef BDM_DEFS_VH
`define BDM_DEFS_VH
`define BDM_ADDR_W 12
`define BDM_BANK_W 4
`define BDM_OFS_W 8
`define BDM_ACCESS_SPLIT 8'h60
`define BDM_ACCESS_LOW_BANK 4'h0
`define BDM_ACCESS_HIGH_BANK 4'hf
`define BDM_CTRL_BASE 12'hf60
`define BDM_BANK_PTR_ADDR 12'hfe0
`define BDM_PC_LOW_ADDR 12'hff9
`define BDM_BANK_PTR_RESET 4'h0
`define BDM_Q_READ 2'h1
`define BDM_Q_WRITE 2'h3
`endif
